// *** rfsme_pkg.sv ***
// constants and carrier types for the reset and fetch strobe block
package rfsme_pkg;

  // ==========================================================
  // timing counts in oscillator clocks and machine cycles; clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [3:0] CLOCKS_STD = 4'hc;
  localparam logic [3:0] CLOCKS_X2 = 4'h6;
  localparam logic [3:0] RESET_MC = 4'h2;
  localparam logic [3:0] HOST_MC = 4'ha;
  localparam logic [3:0] CYCLE_SAT = 4'hf;

  // ==========================================================
  // modes and carriers
  typedef enum logic [1:0] {ST_NORMAL, ST_RESET, ST_HOST} rfsme_mode_type;

  typedef struct packed {
    logic device_reset;
    logic host_mode;
    logic normal_mode;
  } rfsme_status_type;

  typedef struct packed {
    logic out;
    logic oe;
  } rfsme_pin_type;

endpackage

// *** rfsme_mc_timer.sv ***
// machine cycle timer: oscillator clock phase within a machine cycle
`timescale 1ns/10ps
module rfsme_mc_timer #(
  parameter logic [3:0] CLOCKS_STD = rfsme_pkg::CLOCKS_STD,
  parameter logic [3:0] CLOCKS_X2 = rfsme_pkg::CLOCKS_X2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic clocks_x2,
  output logic [3:0] phase,
  output logic mc_tick
);

  logic [3:0] next_phase;
  logic [3:0] last;

  // ==========================================================
  // phase counter
  always_comb
  begin
    last = (clocks_x2 ? CLOCKS_X2 : CLOCKS_STD) - 4'h1;
    // wrap also when the mode drops to fewer clocks mid cycle
    mc_tick = (phase >= last);
    next_phase = mc_tick ? 4'h0 : phase + 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      phase <= 4'h0;
    else if (ce)
      phase <= next_phase;
  end

  // a mode switch may cut the running cycle short, so that tick is not judged
  mc_length_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && mc_tick && $stable(clocks_x2)
      |-> phase == (clocks_x2 ? CLOCKS_X2 - 4'h1 : CLOCKS_STD - 4'h1))
    else $error("machine cycle length wrong");

endmodule

// *** rfsme_top.sv ***
// reset qualification, mode entry and program fetch strobe generation
`timescale 1ns/10ps
module rfsme_top #(
  parameter logic [3:0] CLOCKS_STD = rfsme_pkg::CLOCKS_STD,
  parameter logic [3:0] CLOCKS_X2 = rfsme_pkg::CLOCKS_X2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic rst_pin,
  input wire logic clocks_x2,
  input wire logic fetch_external,
  input wire logic data_access,
  input wire logic program_fetch_strobe_n_in,
  output logic program_fetch_strobe_n_out,
  output logic program_fetch_strobe_n_oe,
  output rfsme_pkg::rfsme_status_type status,
  output logic mc_tick
);

  logic [3:0] phase;
  rfsme_pkg::rfsme_mode_type mode;
  rfsme_pkg::rfsme_mode_type next_mode;
  logic [3:0] rst_cycles;
  logic [3:0] next_rst_cycles;
  logic edge_seen;
  logic next_edge_seen;
  logic strobe_prev;
  logic next_strobe_prev;
  logic strobe_out;
  logic next_strobe_out;
  logic strobe_fall;
  logic qualify;
  logic host_entry;

  // low in the second half of each half machine cycle
  function automatic logic strobe_slot(input logic [3:0] ph, input logic x2);
    logic [3:0] half;
    logic [3:0] pos;
    half = x2 ? (CLOCKS_X2 >> 1) : (CLOCKS_STD >> 1);
    pos = (ph >= half) ? ph - half : ph;
    return pos >= (half >> 1);
  endfunction

  // ==========================================================
  // machine cycle timing
  rfsme_mc_timer #(
    .CLOCKS_STD(CLOCKS_STD),
    .CLOCKS_X2(CLOCKS_X2)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .clocks_x2(clocks_x2),
    .phase(phase),
    .mc_tick(mc_tick)
  );

  // ==========================================================
  // reset qualification and mode selection
  always_comb
  begin
    // only a fall made by the far side counts; our own pulses are ignored
    strobe_fall = !program_fetch_strobe_n_oe && strobe_prev
      && !program_fetch_strobe_n_in;
    // while we drive the pin the previous level is parked high
    next_strobe_prev = program_fetch_strobe_n_oe ? 1'b1 : program_fetch_strobe_n_in;
    next_rst_cycles = 4'h0;
    if (rst_pin)
    begin
      next_rst_cycles = rst_cycles;
      if (mc_tick && rst_cycles != rfsme_pkg::CYCLE_SAT)
        next_rst_cycles = rst_cycles + 4'h1;
    end
    // the fall is caught only while rst_pin is high; it clears along with the count
    next_edge_seen = rst_pin && (edge_seen || strobe_fall);
    // one-shot at the tick completing the second machine cycle
    qualify = rst_pin && mc_tick && rst_cycles == rfsme_pkg::RESET_MC - 4'h1;
    host_entry = rst_pin && edge_seen && rst_cycles > rfsme_pkg::HOST_MC;
    next_mode = mode;
    case (mode)
      rfsme_pkg::ST_NORMAL:
        if (qualify)
          next_mode = rfsme_pkg::ST_RESET;
      rfsme_pkg::ST_RESET:
        if (host_entry)
          next_mode = rfsme_pkg::ST_HOST;
        else if (!rst_pin)
          next_mode = rfsme_pkg::ST_NORMAL;
      rfsme_pkg::ST_HOST:
        if (qualify)
          next_mode = rfsme_pkg::ST_RESET;
      default:
        next_mode = rfsme_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode <= rfsme_pkg::ST_RESET;
      rst_cycles <= 4'h0;
      edge_seen <= 1'b0;
      strobe_prev <= 1'b1;
    end
    else if (ce)
    begin
      mode <= next_mode;
      rst_cycles <= next_rst_cycles;
      edge_seen <= next_edge_seen;
      strobe_prev <= next_strobe_prev;
    end
  end

  // ==========================================================
  // fetch strobe
  always_comb
  begin
    next_strobe_out = 1'b1;
    // a data access cycle drops both pulses of that cycle
    if (next_mode == rfsme_pkg::ST_NORMAL && fetch_external && !data_access)
      next_strobe_out = !strobe_slot(phase, clocks_x2);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      strobe_out <= 1'b1;
    else if (ce)
      strobe_out <= next_strobe_out;
  end

  // pin released outside normal mode so a host can pull it low
  assign program_fetch_strobe_n_out = strobe_out;
  assign program_fetch_strobe_n_oe = (mode == rfsme_pkg::ST_NORMAL);
  // one assignment keeps the status word single-driven
  assign status = '{
    device_reset: (mode == rfsme_pkg::ST_RESET),
    host_mode: (mode == rfsme_pkg::ST_HOST),
    normal_mode: (mode == rfsme_pkg::ST_NORMAL)
  };

  // ==========================================================
  // checks
  sequence s_host_ready;
    rst_pin && edge_seen && rst_cycles > rfsme_pkg::HOST_MC;
  endsequence

  sequence s_rst_second;
    rst_pin && mc_tick && rst_cycles == rfsme_pkg::RESET_MC - 4'h1;
  endsequence

  strobe_internal_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && !fetch_external |=> program_fetch_strobe_n_out)
    else $error("strobe active during internal fetch");

  strobe_slot_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && fetch_external && !data_access && !rst_pin && mode == rfsme_pkg::ST_NORMAL
      && (phase == (clocks_x2 ? 4'h1 : 4'h3) || phase == (clocks_x2 ? 4'h4 : 4'h9))
      |=> !program_fetch_strobe_n_out)
    else $error("strobe pulse missing");

  strobe_gap_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && fetch_external && (phase == 4'h0 || phase == (clocks_x2 ? 4'h3 : 4'h6))
      |=> program_fetch_strobe_n_out)
    else $error("strobe not released between pulses");

  data_skip_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && data_access |=> program_fetch_strobe_n_out)
    else $error("strobe during data access");

  reset_qualify_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && !status.device_reset) and s_rst_second |=> status.device_reset)
    else $error("reset not taken after two machine cycles");

  reset_early_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && status.normal_mode && rst_pin && rst_cycles == 4'h0 |=> !status.device_reset)
    else $error("reset taken too early");

  host_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && status.device_reset) and s_host_ready |=> status.host_mode)
    else $error("host mode not entered");

  normal_exit_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && status.device_reset && !rst_pin |=> status.normal_mode)
    else $error("reset did not exit to normal");

  // a fall while we drive the pin is our own pulse, never a host request
  own_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && program_fetch_strobe_n_oe && !edge_seen |=> !edge_seen)
    else $error("own strobe pulse taken as host edge");

  sequence s_host_fall;
    ce && rst_pin && !program_fetch_strobe_n_oe && program_fetch_strobe_n_in
      ##1 ce && rst_pin && !program_fetch_strobe_n_oe && !program_fetch_strobe_n_in;
  endsequence

  host_fall_a: assert property (@(posedge clk_sys) disable iff (reset)
    s_host_fall |=> edge_seen)
    else $error("host strobe fall not caught");

  host_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && status.host_mode && !rst_pin |=> status.host_mode)
    else $error("host mode lost");

  // the released pin belongs to the host; our flop must stay idle
  released_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && rst_pin && !status.normal_mode |=> program_fetch_strobe_n_out)
    else $error("strobe driven low while pin released");

  count_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    ce && !rst_pin |=> rst_cycles == 4'h0)
    else $error("reset cycle count not cleared");

endmodule

// *** rfsme_host_model.sv ***
// far side model: programming host and pin resolution for the fetch strobe
`timescale 1ns/10ps
module rfsme_host_model (
  input wire logic clk_sys,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_en,
  input wire logic host_level,
  output logic pin
);
  logic last = 1'b1;
  always_ff @(posedge clk_sys)
  begin
    last <= pin;
  end
  // undriven pin has no pull: it toggles so a stale value is never trusted
  always_comb
  begin
    if (dev_oe)
      pin = dev_out;
    else if (host_en)
      pin = host_level;
    else
      pin = ~last;
  end
endmodule

// *** rfsme_top_tb.sv ***
// self-checking testbench for the reset and fetch strobe block
`timescale 1ns/10ps
module rfsme_top_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic rst_pin = 1'b0;
  logic clocks_x2 = 1'b0;
  logic fetch_external = 1'b0;
  logic data_access = 1'b0;
  logic host_en = 1'b1;
  logic host_level = 1'b1;
  logic pin, out, oe, mc_tick;
  rfsme_pkg::rfsme_status_type status;
  int mismatches = 0;
  int samples_checked = 0;
  rfsme_top dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .rst_pin(rst_pin),
    .clocks_x2(clocks_x2), .fetch_external(fetch_external), .data_access(data_access),
    .program_fetch_strobe_n_in(pin), .program_fetch_strobe_n_out(out),
    .program_fetch_strobe_n_oe(oe), .status(status), .mc_tick(mc_tick));
  rfsme_host_model host (.clk_sys(clk_sys), .dev_out(out), .dev_oe(oe),
    .host_en(host_en), .host_level(host_level), .pin(pin));
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // shared helpers
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      mismatches++;
    end
    samples_checked++;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic count_falls(input int n, output logic [3:0] f);
    logic p;
    f = 4'h0;
    p = out;
    repeat (n)
    begin
      wait_n(1);
      if (p === 1'b1 && out === 1'b0)
        f++;
      p = out;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_internal();
    logic [3:0] f;
    @(posedge clk_sys);
    fetch_external <= 1'b0;
    count_falls(30, f);
    check(f, 4'h0);
    check(out, 4'h1);
  endtask
  task automatic t_external(input logic x2);
    logic [3:0] f;
    logic [3:0] t;
    @(posedge clk_sys);
    clocks_x2 <= x2;
    fetch_external <= 1'b1;
    wait_n(12);
    count_falls(x2 ? 24 : 48, f);
    check(f, 4'h8);
    t = 4'h0;
    repeat (x2 ? 24 : 48)
    begin
      wait_n(1);
      if (mc_tick === 1'b1)
        t++;
    end
    check(t, 4'h4);
  endtask
  task automatic t_freeze();
    logic [3:0] o;
    logic k;
    @(posedge clk_sys);
    ce <= 1'b0;
    wait_n(1);
    o = {out, status};
    k = mc_tick;
    wait_n(20);
    check({out, status}, o);
    check(mc_tick, k);
    @(posedge clk_sys);
    ce <= 1'b1;
  endtask
  task automatic t_data();
    logic [3:0] f;
    f = 4'h0;
    do @(negedge clk_sys); while (mc_tick !== 1'b1);
    @(posedge clk_sys);
    data_access <= 1'b1;
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk_sys);
      if (k == 11)
        data_access <= 1'b0;
      #1;
      if (out !== 1'b1)
        f++;
    end
    check(f, 4'h0);
    count_falls(24, f);
    check(f, 4'h4);
  endtask
  task automatic t_reset(input logic host);
    @(posedge clk_sys);
    rst_pin <= 1'b1;
    wait_n(6);
    check(status.device_reset, 4'h0);
    wait_n(20);
    check({1'b0, status}, 4'h4);
    check(oe, 4'h0);
    @(posedge clk_sys);
    host_level <= !host;
    wait_n(88);
    check({1'b0, status}, 4'h4);
    wait_n(30);
    check({1'b0, status}, host ? 4'h2 : 4'h4);
    @(posedge clk_sys);
    rst_pin <= 1'b0;
    wait_n(3);
    check({1'b0, status}, host ? 4'h2 : 4'h1);
    check(oe, host ? 4'h0 : 4'h1);
    @(posedge clk_sys);
    host_level <= 1'b1;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    wait_n(2);
    t_internal();
    t_external(1'b0);
    t_external(1'b1);
    t_external(1'b0);
    t_freeze();
    t_data();
    t_reset(1'b0);
    t_reset(1'b1);
    t_reset(1'b0);
    report_and_stop();
  end
  initial
  begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule
